// File: include/ptm_pkg.sv
`default_nettype none
package ptm_pkg;
  // ---------------------------------------------
  // Object indices
  // ---------------------------------------------
  localparam int IDX_W = 16;
  localparam logic [IDX_W-1:0] IDX_ERR_CODE = 16'h603f;
  localparam logic [IDX_W-1:0] IDX_CMD_WORD = 16'h6040;
  localparam logic [IDX_W-1:0] IDX_STATE_WORD = 16'h6041;
  localparam logic [IDX_W-1:0] IDX_MODE_SEL = 16'h6060;
  localparam logic [IDX_W-1:0] IDX_MODE_SHOWN = 16'h6061;
  localparam logic [IDX_W-1:0] IDX_SETPOINT = 16'h6071;
  localparam logic [IDX_W-1:0] IDX_TQ_CEIL = 16'h6072;
  localparam logic [IDX_W-1:0] IDX_CUR_CEIL = 16'h6073;
  localparam logic [IDX_W-1:0] IDX_GEN_OUT = 16'h6074;
  localparam logic [IDX_W-1:0] IDX_NAME_CUR = 16'h6075;
  localparam logic [IDX_W-1:0] IDX_NAME_TQ = 16'h6076;
  localparam logic [IDX_W-1:0] IDX_MEAS_TQ = 16'h6077;
  localparam logic [IDX_W-1:0] IDX_MEAS_CUR = 16'h6078;
  localparam logic [IDX_W-1:0] IDX_BUS_VOLT = 16'h6079;
  localparam logic [IDX_W-1:0] IDX_RAMP_RATE = 16'h6087;
  localparam logic [IDX_W-1:0] IDX_RAMP_SHAPE = 16'h6088;
  localparam logic [IDX_W-1:0] IDX_FWD_LIM = 16'h60e0;
  localparam logic [IDX_W-1:0] IDX_REV_LIM = 16'h60e1;
  // ---------------------------------------------
  // Codes and bit positions
  // ---------------------------------------------
  localparam logic [7:0] MODE_TORQUE = 8'h04;
  localparam logic [15:0] SHAPE_IMMEDIATE = 16'hffff;
  localparam logic [15:0] SHAPE_LINEAR = 16'h0000;
  localparam logic [15:0] SHAPE_SIN2 = 16'h0001;
  localparam int CW_FRESET = 7;
  localparam int CW_HALT = 8;
  localparam int SW_RTSO = 0;
  localparam int SW_ON = 1;
  localparam int SW_OPEN = 2;
  localparam int SW_FAULT = 3;
  localparam int SW_QS_N = 5;
  localparam int SW_SOD = 6;
  localparam int SW_TR = 10;
  localparam logic [31:0] ABORT_NONE = 32'h0000_0000;
  localparam logic [31:0] ABORT_RANGE = 32'h0604_0030;
  localparam logic [31:0] ABORT_TOO_HIGH = 32'h0609_0031;
  localparam logic [31:0] ABORT_NO_DATA = 32'h0800_0024;
  // ---------------------------------------------
  // Bounds and reset values
  // ---------------------------------------------
  localparam logic [31:0] VAL32_MAX = 32'h7fff_ffff;
  localparam logic [15:0] PERMILLE_MAX = 16'h7fff;
  localparam logic [31:0] NOMINAL_TO_MA = 32'h0000_0064;
  localparam logic [15:0] RST_CMD = 16'h0000;
  localparam logic [7:0] RST_MODE = 8'h00;
  localparam logic [15:0] RST_PERMILLE = 16'h03e8;
  localparam logic [31:0] RST_NAME = 32'h0000_03e8;
  localparam logic [31:0] RST_RATE = 32'h0000_03e8;
  localparam logic [15:0] RST_SHAPE = SHAPE_LINEAR;
  // ---------------------------------------------
  // Timing
  // ---------------------------------------------
  localparam int CLK_FREQ_MHZ = 50;
  localparam int TICK_PERIOD_US = 1000;
  localparam int TICK_CYC = TICK_PERIOD_US * CLK_FREQ_MHZ;
  localparam int TICKS_PER_S = 1000000 / TICK_PERIOD_US;
  localparam int SLOPE_W = 32;
  localparam int FILT_SHIFT = 4;
  typedef enum logic [4:0] {
    ST_DISABLED = 5'h01,
    ST_READY = 5'h02,
    ST_ON = 5'h04,
    ST_ENABLED = 5'h08,
    ST_FAULT = 5'h10
  } ptm_state_type;
endpackage
`default_nettype wire

// File: core/ptm_ramp.sv
`default_nettype none
module ptm_ramp #(
  parameter int WIDTH = 16
)(
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Control
  input wire logic clear_in,
  input wire logic tick_in,
  input wire logic immediate_in,
  input wire logic signed [WIDTH-1:0] target_in,
  input wire logic [ptm_pkg::SLOPE_W-1:0] slope_in,
  // Result
  output logic signed [WIDTH-1:0] demand_out
);
  import ptm_pkg::*;

  if (WIDTH < 2)
  begin : g_bad_width
    $error("WIDTH must be at least 2");
  end

  localparam int ACC_W = SLOPE_W + 1;
  localparam logic [ACC_W-1:0] ACC_STEP = ACC_W'(TICKS_PER_S);
  localparam logic signed [WIDTH-1:0] ONE = WIDTH'(1);

  typedef struct packed {
    logic signed [WIDTH-1:0] demand;
    logic [ACC_W-1:0] acc;
  } ptm_ramp_type;

  ptm_ramp_type st_ff;
  ptm_ramp_type nxt_st;
  logic [ACC_W:0] sum;
  logic [ACC_W-1:0] acc_t;

  // ---------------------------------------------
  // Linear ramp, one unit per clock from the credit
  // ---------------------------------------------
  // The credit saturates instead of wrapping; a full-scale swing needs far less
  // credit than the 33-bit accumulator holds, so no rate is lost in practice.
  always_comb
  begin
    nxt_st = st_ff;
    sum = {1'b0, st_ff.acc} + {2'b00, slope_in};
    acc_t = st_ff.acc;
    if (clear_in)
      nxt_st = '0;
    else if (immediate_in)
    begin
      nxt_st.demand = target_in;
      nxt_st.acc = '0;
    end
    else if (st_ff.demand == target_in)
      nxt_st.acc = '0;
    else
    begin
      if (tick_in)
        acc_t = sum[ACC_W] ? {ACC_W{1'b1}} : sum[ACC_W-1:0];
      if (acc_t >= ACC_STEP)
      begin
        acc_t = acc_t - ACC_STEP;
        if (st_ff.demand < target_in)
          nxt_st.demand = st_ff.demand + ONE;
        else
          nxt_st.demand = st_ff.demand - ONE;
      end
      nxt_st.acc = acc_t;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      st_ff <= '0;
    else
      st_ff <= nxt_st;
  end

  assign demand_out = st_ff.demand;
endmodule // ptm_ramp
`default_nettype wire

// File: core/ptm_core.sv
`default_nettype none
// Behaviour
// - Mode 4 selects torque operation; the shown mode follows the accepted selection.
// - Torque only flows while the drive state machine is operation enabled.
// - A zero set-point ends motion and holds zero torque.
// - Command bit 8 halts the axis when set; motion runs when clear.
// - A detected error stops motion and enters the fault state.
// - Disable operation, disable voltage or quick stop leaving enabled stop motion.
// - An active safe torque off input stops motion.
// - State bit 10: target reached, or under halt axis standing still.
// - No dynamic stop in this mode; torque control simply continues or zeroes.
// - Starting the mode clears the internal set-point before new set-points.
// - With power on and no halt a new set-point acts at once.
// - Ramp shape -1 jumps straight to the set-point.
// - Linear shape moves at the ramp rate in per-mille rated current per second.
// - Ramp shape 1 (squared sine) is unsupported and refused.
// - Mode-specific state bits clear on mode change, power off or quick stop.
// - Set-point is signed 16 bit per-mille of rated current, driving torque current.
// - A set-point above the current ceiling is refused as too high.
// - Nameplate current is unsigned 32 bit mA, accepted 1 to 2147483647.
// - Nameplate current may not exceed the nominal rated current; device checks.
// - Torque is clamped to the forward and reverse limits.
// - Measured torque shows the instant reference, measured current a filtered one.
// - An unavailable ramp shape is refused with the no-data code.
module ptm_core #(
  parameter int TICK_CYCLES = ptm_pkg::TICK_CYC,
  parameter logic [31:0] ABORT_READ_ONLY = 32'h0000_0001,
  parameter logic [31:0] ABORT_NO_OBJECT = 32'h0000_0002
)(
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Object dictionary access
  input wire logic od_req_in,
  input wire logic od_wr_in,
  input wire logic [ptm_pkg::IDX_W-1:0] od_index_in,
  input wire logic [31:0] od_wdata_in,
  output logic od_ack_out,
  output logic [31:0] od_rdata_out,
  output logic [31:0] od_abort_out,
  // Drive conditions
  input wire logic safe_torque_off_input_in,
  input wire logic fault_in,
  input wire logic [15:0] fault_code_in,
  input wire logic axis_still_in,
  input wire logic [15:0] nominal_current_in,
  input wire logic [31:0] dc_link_mv_in,
  // Power stage
  output logic power_stage_out,
  output logic signed [15:0] torque_producing_current_out
);
  import ptm_pkg::*;

  if (TICK_CYCLES < 2)
  begin : g_bad_tick
    $error("TICK_CYCLES must be at least 2");
  end

  localparam int TW = $clog2(TICK_CYCLES);
  localparam int FW = 16 + FILT_SHIFT;

  typedef struct packed {
    ptm_state_type state;
    logic [15:0] cw;
    logic fr_prev;
    logic [7:0] mode_sel;
    logic [7:0] mode_shown;
    logic [15:0] setpoint;
    logic [15:0] tq_ceil;
    logic [15:0] cur_ceil;
    logic [31:0] name_cur;
    logic [31:0] name_tq;
    logic [31:0] rate;
    logic [15:0] shape;
    logic [15:0] fwd_lim;
    logic [15:0] rev_lim;
    logic [15:0] err_code;
    logic tr;
    logic [15:0] tq_cmd;
    logic [FW-1:0] filt;
    logic [TW-1:0] tick_cnt;
    logic tick;
    logic [2:0] off_sync;
    logic off_req;
    logic power;
    logic ack;
    logic [31:0] rdata;
    logic [31:0] abort;
  } ptm_core_type;

  localparam ptm_core_type RST_ST = '{
    state: ST_DISABLED,
    cw: RST_CMD,
    mode_sel: RST_MODE,
    mode_shown: RST_MODE,
    tq_ceil: RST_PERMILLE,
    cur_ceil: RST_PERMILLE,
    name_cur: RST_NAME,
    name_tq: RST_NAME,
    rate: RST_RATE,
    shape: RST_SHAPE,
    fwd_lim: RST_PERMILLE,
    rev_lim: RST_PERMILLE,
    default: '0
  };

  ptm_core_type st_ff;
  ptm_core_type nxt_st;

  // ---------------------------------------------
  // Decoding helpers
  // ---------------------------------------------
  function automatic logic f_dis_volt(input logic [15:0] cw);
    f_dis_volt = ~cw[1];
  endfunction

  function automatic logic f_qstop(input logic [15:0] cw);
    f_qstop = cw[1] & ~cw[2];
  endfunction

  function automatic logic f_shutdown(input logic [15:0] cw);
    f_shutdown = (cw[2:0] == 3'h6);
  endfunction

  function automatic logic f_switch_on(input logic [15:0] cw);
    f_switch_on = (cw[3:0] == 4'h7);
  endfunction

  function automatic logic f_enable(input logic [15:0] cw);
    f_enable = (cw[3:0] == 4'hf);
  endfunction

  // Limits above PERMILLE_MAX are refused at write, so the 17-bit
  // bounds below never wrap when cut back to 16 bits.
  function automatic logic [15:0] f_clamp(input logic [15:0] v, input logic [15:0] hi,
                                          input logic [15:0] lo, input logic [15:0] cap);
    logic signed [16:0] h;
    logic signed [16:0] l;
    logic signed [16:0] x;
    h = $signed({1'b0, (hi < cap) ? hi : cap});
    l = -$signed({1'b0, (lo < cap) ? lo : cap});
    x = $signed({v[15], v});
    if (x > h)
      f_clamp = h[15:0];
    else if (x < l)
      f_clamp = l[15:0];
    else
      f_clamp = v;
  endfunction

  function automatic logic [15:0] f_status(input ptm_state_type s, input logic tr);
    logic [15:0] w;
    w = '0;
    w[SW_TR] = tr;
    case (s)
      ST_DISABLED: w[SW_SOD] = 1'b1;
      ST_READY:
      begin
        w[SW_RTSO] = 1'b1;
        w[SW_QS_N] = 1'b1;
      end
      ST_ON:
      begin
        w[SW_RTSO] = 1'b1;
        w[SW_ON] = 1'b1;
        w[SW_QS_N] = 1'b1;
      end
      ST_ENABLED:
      begin
        w[SW_RTSO] = 1'b1;
        w[SW_ON] = 1'b1;
        w[SW_OPEN] = 1'b1;
        w[SW_QS_N] = 1'b1;
      end
      ST_FAULT: w[SW_FAULT] = 1'b1;
      default: w = '0;
    endcase
    f_status = w;
  endfunction

  // ---------------------------------------------
  // Torque path
  // ---------------------------------------------
  logic run;
  logic halt;
  logic [15:0] eff_tgt;
  logic [15:0] demand;
  logic ramp_clear;
  logic fr_edge;
  logic enter_en;
  logic [16:0] sp_x;
  logic too_high;
  logic [31:0] nom_ma;
  logic [31:0] rd_val;
  logic [31:0] rd_abort;

  assign run = (st_ff.state == ST_ENABLED) && (st_ff.mode_shown == MODE_TORQUE)
               && !st_ff.off_req && !fault_in;
  assign halt = st_ff.cw[CW_HALT];
  // Halt steers the ramp toward zero with the configured ramp shape and rate
  assign eff_tgt = halt ? 16'h0000 : f_clamp(st_ff.setpoint, st_ff.fwd_lim, st_ff.rev_lim, st_ff.cur_ceil);
  assign ramp_clear = !run;

  ptm_ramp #(
    .WIDTH(16)
  ) u_ramp (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .clear_in(ramp_clear),
    .tick_in(st_ff.tick),
    .immediate_in(st_ff.shape == SHAPE_IMMEDIATE),
    .target_in(eff_tgt),
    .slope_in(st_ff.rate),
    .demand_out(demand)
  );

  // ---------------------------------------------
  // Next state
  // ---------------------------------------------
  always_comb
  begin
    nxt_st = st_ff;
    fr_edge = st_ff.cw[CW_FRESET] & ~st_ff.fr_prev;
    enter_en = 1'b0;
    sp_x = {od_wdata_in[15], od_wdata_in[15:0]};
    too_high = ($signed(sp_x) > $signed({1'b0, st_ff.cur_ceil}))
               || ($signed(sp_x) < -$signed({1'b0, st_ff.cur_ceil}));
    nom_ma = 32'(nominal_current_in) * NOMINAL_TO_MA;
    rd_val = '0;
    rd_abort = ABORT_NONE;
    nxt_st.fr_prev = st_ff.cw[CW_FRESET];
    nxt_st.mode_shown = st_ff.mode_sel;

    // Safe torque off: three stages, a change counts once two agree
    nxt_st.off_sync = {st_ff.off_sync[1:0], safe_torque_off_input_in};
    if (st_ff.off_sync[1] == st_ff.off_sync[2])
      nxt_st.off_req = st_ff.off_sync[2];

    // Control tick
    nxt_st.tick = 1'b0;
    if (st_ff.tick_cnt == TW'(TICK_CYCLES - 1))
    begin
      nxt_st.tick_cnt = '0;
      nxt_st.tick = 1'b1;
    end
    else
      nxt_st.tick_cnt = st_ff.tick_cnt + TW'(1);

    // Drive state machine
    if (fault_in && (st_ff.state != ST_FAULT))
    begin
      nxt_st.state = ST_FAULT;
      nxt_st.err_code = fault_code_in;
    end
    else
      case (st_ff.state)
        ST_DISABLED:
          if (f_shutdown(st_ff.cw))
            nxt_st.state = ST_READY;
        ST_READY:
          if (f_dis_volt(st_ff.cw) || f_qstop(st_ff.cw))
            nxt_st.state = ST_DISABLED;
          else if (f_enable(st_ff.cw))
            nxt_st.state = ST_ENABLED;
          else if (f_switch_on(st_ff.cw))
            nxt_st.state = ST_ON;
        ST_ON:
          if (f_dis_volt(st_ff.cw) || f_qstop(st_ff.cw))
            nxt_st.state = ST_DISABLED;
          else if (f_shutdown(st_ff.cw))
            nxt_st.state = ST_READY;
          else if (f_enable(st_ff.cw))
            nxt_st.state = ST_ENABLED;
        ST_ENABLED:
          if (f_dis_volt(st_ff.cw) || f_qstop(st_ff.cw))
            nxt_st.state = ST_DISABLED;
          else if (f_shutdown(st_ff.cw))
            nxt_st.state = ST_READY;
          else if (f_switch_on(st_ff.cw))
            nxt_st.state = ST_ON;
        ST_FAULT:
          if (fr_edge && !fault_in)
            nxt_st.state = ST_DISABLED;
        default: nxt_st.state = ST_DISABLED;
      endcase
    enter_en = (nxt_st.state == ST_ENABLED) && (st_ff.state != ST_ENABLED);
    nxt_st.power = (nxt_st.state == ST_ENABLED);

    // Dynamic braking is never engaged here: the current loop keeps control
    nxt_st.tq_cmd = run ? demand : 16'h0000;

    // First-order filter of the reference, once per tick
    if (st_ff.tick)
      nxt_st.filt = st_ff.filt + {{FILT_SHIFT{st_ff.tq_cmd[15]}}, st_ff.tq_cmd}
                    - FW'($signed(st_ff.filt) >>> FILT_SHIFT);

    if ((st_ff.state != ST_ENABLED) || (st_ff.mode_sel != st_ff.mode_shown)
        || (st_ff.mode_shown != MODE_TORQUE))
      nxt_st.tr = 1'b0;
    else if (halt)
      nxt_st.tr = axis_still_in;
    else
      nxt_st.tr = (demand == eff_tgt);

    // Read multiplexer
    case (od_index_in)
      IDX_ERR_CODE: rd_val = {16'h0000, st_ff.err_code};
      IDX_CMD_WORD: rd_val = {16'h0000, st_ff.cw};
      IDX_STATE_WORD: rd_val = {16'h0000, f_status(st_ff.state, st_ff.tr)};
      IDX_MODE_SEL: rd_val = {24'h00_0000, st_ff.mode_sel};
      IDX_MODE_SHOWN: rd_val = {24'h00_0000, st_ff.mode_shown};
      IDX_SETPOINT: rd_val = {{16{st_ff.setpoint[15]}}, st_ff.setpoint};
      IDX_TQ_CEIL: rd_val = {16'h0000, st_ff.tq_ceil};
      IDX_CUR_CEIL: rd_val = {16'h0000, st_ff.cur_ceil};
      IDX_GEN_OUT: rd_val = {{16{demand[15]}}, demand};
      IDX_NAME_CUR: rd_val = st_ff.name_cur;
      IDX_NAME_TQ: rd_val = st_ff.name_tq;
      IDX_MEAS_TQ: rd_val = {{16{st_ff.tq_cmd[15]}}, st_ff.tq_cmd};
      IDX_MEAS_CUR: rd_val = {{16{st_ff.filt[FW-1]}}, st_ff.filt[FW-1:FILT_SHIFT]};
      IDX_BUS_VOLT: rd_val = dc_link_mv_in;
      IDX_RAMP_RATE: rd_val = st_ff.rate;
      IDX_RAMP_SHAPE: rd_val = {{16{st_ff.shape[15]}}, st_ff.shape};
      IDX_FWD_LIM: rd_val = {16'h0000, st_ff.fwd_lim};
      IDX_REV_LIM: rd_val = {16'h0000, st_ff.rev_lim};
      default: rd_abort = ABORT_NO_OBJECT;
    endcase

    // Object access: answered on the following edge
    nxt_st.ack = od_req_in;
    if (od_req_in)
    begin
      nxt_st.rdata = '0;
      nxt_st.abort = ABORT_NONE;
      if (!od_wr_in)
      begin
        nxt_st.rdata = (rd_abort == ABORT_NONE) ? rd_val : 32'h0000_0000;
        nxt_st.abort = rd_abort;
      end
      else
        case (od_index_in)
          IDX_CMD_WORD: nxt_st.cw = od_wdata_in[15:0];
          IDX_MODE_SEL: nxt_st.mode_sel = od_wdata_in[7:0];
          IDX_SETPOINT:
            if (too_high)
              nxt_st.abort = ABORT_TOO_HIGH;
            else
              nxt_st.setpoint = od_wdata_in[15:0];
          IDX_TQ_CEIL:
            if (od_wdata_in[15:0] > PERMILLE_MAX)
              nxt_st.abort = ABORT_RANGE;
            else
              nxt_st.tq_ceil = od_wdata_in[15:0];
          IDX_CUR_CEIL:
            if ((od_wdata_in[15:0] == 16'h0000) || (od_wdata_in[15:0] > PERMILLE_MAX))
              nxt_st.abort = ABORT_RANGE;
            else
              nxt_st.cur_ceil = od_wdata_in[15:0];
          IDX_NAME_CUR:
            if ((od_wdata_in == 32'h0000_0000) || (od_wdata_in > VAL32_MAX))
              nxt_st.abort = ABORT_RANGE;
            else if (od_wdata_in > nom_ma)
              nxt_st.abort = ABORT_TOO_HIGH;
            else
              nxt_st.name_cur = od_wdata_in;
          IDX_NAME_TQ: nxt_st.name_tq = od_wdata_in;
          IDX_RAMP_RATE:
            if ((od_wdata_in == 32'h0000_0000) || (od_wdata_in > VAL32_MAX))
              nxt_st.abort = ABORT_RANGE;
            else
              nxt_st.rate = od_wdata_in;
          IDX_RAMP_SHAPE:
            if ((od_wdata_in[15:0] == SHAPE_IMMEDIATE) || (od_wdata_in[15:0] == SHAPE_LINEAR))
              nxt_st.shape = od_wdata_in[15:0];
            else
              nxt_st.abort = ABORT_NO_DATA;
          IDX_FWD_LIM:
            if (od_wdata_in[15:0] > PERMILLE_MAX)
              nxt_st.abort = ABORT_RANGE;
            else
              nxt_st.fwd_lim = od_wdata_in[15:0];
          IDX_REV_LIM:
            if (od_wdata_in[15:0] > PERMILLE_MAX)
              nxt_st.abort = ABORT_RANGE;
            else
              nxt_st.rev_lim = od_wdata_in[15:0];
          IDX_ERR_CODE, IDX_STATE_WORD, IDX_MODE_SHOWN, IDX_GEN_OUT,
          IDX_MEAS_TQ, IDX_MEAS_CUR, IDX_BUS_VOLT: nxt_st.abort = ABORT_READ_ONLY;
          default: nxt_st.abort = ABORT_NO_OBJECT;
        endcase
    end

    // Entering operation drops any set-point, even one written this cycle
    if (enter_en)
      nxt_st.setpoint = 16'h0000;
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      st_ff <= RST_ST;
    else
      st_ff <= nxt_st;
  end

  // ---------------------------------------------
  // Outputs
  // ---------------------------------------------
  assign od_ack_out = st_ff.ack;
  assign od_rdata_out = st_ff.rdata;
  assign od_abort_out = st_ff.abort;
  assign power_stage_out = st_ff.power;
  assign torque_producing_current_out = st_ff.tq_cmd;
endmodule // ptm_core
`default_nettype wire

// File: tb/ptm_core_monitor.sv
`default_nettype none
module ptm_core_monitor #(
  parameter logic [31:0] ABORT_READ_ONLY = 32'h0000_0001,
  parameter logic [31:0] ABORT_NO_OBJECT = 32'h0000_0002
)(
  // Clock, reset and object access
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic od_req_in,
  input wire logic od_wr_in,
  input wire logic [15:0] od_index_in,
  input wire logic [31:0] od_wdata_in,
  input wire logic od_ack_out,
  input wire logic [31:0] od_rdata_out,
  input wire logic [31:0] od_abort_out,
  // Drive conditions
  input wire logic safe_torque_off_input_in,
  input wire logic fault_in,
  input wire logic power_stage_out,
  input wire logic signed [15:0] torque_producing_current_out
);
  timeunit 1ns;
  timeprecision 1ps;
  import ptm_pkg::*;
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  // ---
  // Access and stop checks
  // ---
  sequence s_wr(logic [15:0] idx, logic [31:0] val);
    od_req_in && od_wr_in && od_index_in == idx && od_wdata_in == val;
  endsequence
  a_ack_follows_req: assert property (od_req_in |=> od_ack_out)
    else $error("answer missing");
  a_write_no_data: assert property (od_ack_out && $past(od_wr_in) |-> od_rdata_out == '0)
    else $error("write answered with data");
  a_shape_refused: assert property (s_wr(IDX_RAMP_SHAPE, 32'h1) |=> od_abort_out == ABORT_NO_DATA)
    else $error("squared sine shape taken");
  a_zero_nameplate: assert property (s_wr(IDX_NAME_CUR, '0) |=> od_abort_out == ABORT_RANGE)
    else $error("zero nameplate current taken");
  a_readonly_write: assert property (od_req_in && od_wr_in && od_index_in == IDX_STATE_WORD
    |=> od_abort_out == ABORT_READ_ONLY)
    else $error("state word write taken");
  a_unknown_index: assert property (od_req_in && od_index_in < IDX_ERR_CODE |=> od_abort_out == ABORT_NO_OBJECT)
    else $error("unknown object answered");
  a_fault_zero: assert property (fault_in |=> torque_producing_current_out == 16'h0000)
    else $error("torque during fault");
  a_fault_power: assert property (fault_in |-> ##2 !power_stage_out)
    else $error("power stage on after fault");
  a_safe_off_zero: assert property (safe_torque_off_input_in [*7] |-> torque_producing_current_out == 16'h0000)
    else $error("torque with safe torque off");
  a_off_zero: assert property (!power_stage_out [*2] |-> torque_producing_current_out == 16'h0000)
    else $error("torque while not enabled");
endmodule // ptm_core_monitor
bind ptm_core ptm_core_monitor #(.ABORT_READ_ONLY(ABORT_READ_ONLY), .ABORT_NO_OBJECT(ABORT_NO_OBJECT))
  i_ptm_core_monitor (.clk_in(clk_in), .rst_in(rst_in), .od_req_in(od_req_in), .od_wr_in(od_wr_in),
  .od_index_in(od_index_in), .od_wdata_in(od_wdata_in), .od_ack_out(od_ack_out), .od_rdata_out(od_rdata_out),
  .od_abort_out(od_abort_out), .safe_torque_off_input_in(safe_torque_off_input_in), .fault_in(fault_in),
  .power_stage_out(power_stage_out), .torque_producing_current_out(torque_producing_current_out));
`default_nettype wire

// File: tb/ptm_master.sv
`default_nettype none
module ptm_master (
  // Answer side
  input wire logic clk_in,
  input wire logic ack_in,
  input wire logic [31:0] rdata_in,
  input wire logic [31:0] abort_in,
  // Request side
  output logic req_out,
  output logic wr_out,
  output logic [15:0] index_out,
  output logic [31:0] wdata_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {req_out, wr_out, index_out, wdata_out} = '0;
  // ---
  // One object access
  // ---
  task automatic access(input logic w, input logic [15:0] i, input logic [31:0] d,
    output logic [31:0] q, output logic [31:0] a, output logic ok);
    int n;
    @(posedge clk_in);
    #1;
    {req_out, wr_out, index_out, wdata_out} = {1'b1, w, i, d};
    @(posedge clk_in);
    #1;
    // Each cycle with the request high is a new access; released lines show garbage
    {req_out, index_out, wdata_out} = {1'b0, ~i, ~d};
    n = 0;
    while (ack_in !== 1'b1 && n < 8)
    begin
      @(posedge clk_in);
      #1;
      n++;
    end
    q = rdata_in;
    a = abort_in;
    ok = (ack_in === 1'b1);
  endtask
endmodule // ptm_master
`default_nettype wire

// File: tb/test_profile_torque_mode_control.sv
`default_nettype none
module test_profile_torque_mode_control;
  timeunit 1ns;
  timeprecision 1ps;
  import ptm_pkg::*;
  localparam logic [31:0] AB_RO = 32'h0000_0001;
  localparam logic [31:0] AB_NO = 32'h0000_0002;
  logic clk_in, rst_in, req, wr, ack, safe_off, flt, still, pwr;
  logic [15:0] idx;
  logic [31:0] wdata, rdata, abort;
  logic signed [15:0] tq;
  int fails, compares;
  ptm_core #(.TICK_CYCLES(20), .ABORT_READ_ONLY(AB_RO), .ABORT_NO_OBJECT(AB_NO)) i_ptm_core (
    .clk_in(clk_in), .rst_in(rst_in), .od_req_in(req), .od_wr_in(wr), .od_index_in(idx),
    .od_wdata_in(wdata), .od_ack_out(ack), .od_rdata_out(rdata), .od_abort_out(abort),
    .safe_torque_off_input_in(safe_off), .fault_in(flt), .fault_code_in(16'h1234),
    .axis_still_in(still), .nominal_current_in(16'h007d), .dc_link_mv_in(32'h0001_2345),
    .power_stage_out(pwr), .torque_producing_current_out(tq));
  ptm_master i_ptm_master (.clk_in(clk_in), .ack_in(ack), .rdata_in(rdata), .abort_in(abort),
    .req_out(req), .wr_out(wr), .index_out(idx), .wdata_out(wdata));
  always #10 clk_in = ~clk_in;
  // ---
  // Shared tasks
  // ---
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e)
    begin
      fails++;
      $display("wrong value %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic report_and_stop();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic acc(input logic w, input logic [15:0] i, input logic [31:0] d, e, ea);
    logic [31:0] q, a;
    logic ok;
    i_ptm_master.access(w, i, d, q, a, ok);
    if (!ok)
    begin
      fails++;
      report_and_stop();
    end
    chk("read data", e, q);
    chk("abort code", ea, a);
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  initial
  begin
    clk_in = 0;
    rst_in = 1;
    {safe_off, flt, still} = '0;
    idle(20);
    rst_in = 0;
    acc(0, IDX_CMD_WORD, '0, '0, '0);
    acc(0, IDX_CUR_CEIL, '0, 32'h3e8, '0);
    acc(0, IDX_STATE_WORD, '0, 32'h40, '0);
    acc(0, 16'h6000, '0, '0, AB_NO);
    acc(1, IDX_STATE_WORD, 32'h1, '0, AB_RO);
    $display("test 1 done");
    acc(1, IDX_RAMP_SHAPE, 32'h1, '0, ABORT_NO_DATA);
    acc(1, IDX_RAMP_SHAPE, 32'h5, '0, ABORT_NO_DATA);
    acc(1, IDX_NAME_CUR, '0, '0, ABORT_RANGE);
    acc(1, IDX_NAME_CUR, 32'h30d5, '0, ABORT_TOO_HIGH);
    acc(1, IDX_NAME_CUR, 32'h30d4, '0, '0);
    acc(1, IDX_RAMP_RATE, '0, '0, ABORT_RANGE);
    acc(1, IDX_SETPOINT, 32'h3e9, '0, ABORT_TOO_HIGH);
    acc(0, IDX_SETPOINT, '0, '0, '0);
    $display("test 2 done");
    acc(1, IDX_MODE_SEL, 32'h4, '0, '0);
    acc(0, IDX_MODE_SHOWN, '0, 32'h4, '0);
    acc(1, IDX_RAMP_SHAPE, 32'hffff, '0, '0);
    acc(1, IDX_CMD_WORD, 32'h6, '0, '0);
    idle(3);
    acc(0, IDX_STATE_WORD, '0, 32'h21, '0);
    acc(1, IDX_CMD_WORD, 32'hf, '0, '0);
    idle(3);
    chk("power stage", 32'h1, pwr);
    acc(0, IDX_STATE_WORD, '0, 32'h427, '0);
    acc(1, IDX_SETPOINT, 32'h12c, '0, '0);
    idle(3);
    chk("torque", 32'h12c, tq);
    acc(0, IDX_MEAS_TQ, '0, 32'h12c, '0);
    acc(1, IDX_FWD_LIM, 32'hc8, '0, '0);
    acc(1, IDX_REV_LIM, 32'h64, '0, '0);
    idle(3);
    chk("torque", 32'hc8, tq);
    acc(1, IDX_SETPOINT, 32'hfe0c, '0, '0);
    idle(3);
    chk("torque", 32'hffff_ff9c, tq);
    acc(0, IDX_SETPOINT, '0, 32'hffff_fe0c, '0);
    acc(1, IDX_SETPOINT, '0, '0, '0);
    idle(3);
    chk("torque", '0, tq);
    $display("test 3 done");
    // One step per tick at the default rate, so ten steps need ten ticks
    acc(1, IDX_RAMP_SHAPE, '0, '0, '0);
    acc(1, IDX_SETPOINT, 32'ha, '0, '0);
    idle(260);
    chk("torque", 32'ha, tq);
    acc(0, IDX_GEN_OUT, '0, 32'ha, '0);
    acc(1, IDX_CMD_WORD, 32'h10f, '0, '0);
    idle(3);
    acc(0, IDX_STATE_WORD, '0, 32'h27, '0);
    idle(260);
    chk("torque", '0, tq);
    still = 1;
    idle(3);
    acc(0, IDX_STATE_WORD, '0, 32'h427, '0);
    still = 0;
    acc(1, IDX_CMD_WORD, 32'hf, '0, '0);
    acc(1, IDX_RAMP_SHAPE, 32'hffff, '0, '0);
    acc(1, IDX_SETPOINT, 32'h64, '0, '0);
    safe_off = 1;
    idle(8);
    chk("torque", '0, tq);
    safe_off = 0;
    $display("test 4 done");
    acc(1, IDX_CMD_WORD, 32'h2, '0, '0);
    idle(3);
    chk("torque", '0, tq);
    chk("power stage", '0, pwr);
    acc(0, IDX_STATE_WORD, '0, 32'h40, '0);
    acc(1, IDX_CMD_WORD, 32'h6, '0, '0);
    acc(1, IDX_CMD_WORD, 32'hf, '0, '0);
    idle(3);
    acc(0, IDX_SETPOINT, '0, '0, '0);
    acc(1, IDX_SETPOINT, 32'h64, '0, '0);
    flt = 1;
    idle(3);
    chk("torque", '0, tq);
    flt = 0;
    acc(0, IDX_STATE_WORD, '0, 32'h8, '0);
    acc(0, IDX_ERR_CODE, '0, 32'h1234, '0);
    acc(1, IDX_CMD_WORD, 32'h80, '0, '0);
    idle(3);
    acc(0, IDX_STATE_WORD, '0, 32'h40, '0);
    $display("test 5 done");
    report_and_stop();
  end
endmodule // test_profile_torque_mode_control
`default_nettype wire
